//--- src/acmc_consts.svh
// Constants for the scaling configuration and mode control block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef ACMC_CONSTS_SVH
`define ACMC_CONSTS_SVH

// Command codes of the registers
`define ACMC_CODE_LINK_CONFIG 8'hE9
`define ACMC_CODE_DEVICE_ID 8'hEA
`define ACMC_CODE_INIT_REF 8'hEB

// Factory reset values
`define ACMC_RESET_DEVICE_ID 4'h5
`define ACMC_RESET_INIT_REF 10'h1F4
`define ACMC_RESET_PAYLOAD 2'h1
`define ACMC_RESET_DOUBLE 1'h0
`define ACMC_RESET_SLEW 1'h0
`define ACMC_RESET_ENABLE 1'h0
`define ACMC_RESET_STARTUP 1'h0

// Field positions in the link config register
`define ACMC_CFG_ENABLE 5
`define ACMC_CFG_STARTUP 4
`define ACMC_CFG_DOUBLE 3
`define ACMC_CFG_PAYLOAD_HI 2
`define ACMC_CFG_PAYLOAD_LO 1
`define ACMC_CFG_SLEW 0

// Field widths
`define ACMC_ID_BITS 4
`define ACMC_REF_BITS 10

// Payload size codes and their widths in bits
`define ACMC_PAYLOAD_8 2'h0
`define ACMC_PAYLOAD_10 2'h1
`define ACMC_PAYLOAD_12 2'h2
`define ACMC_PAYLOAD_16 2'h3
`define ACMC_WIDTH_8 5'h08
`define ACMC_WIDTH_10 5'h0A
`define ACMC_WIDTH_12 5'h0C
`define ACMC_WIDTH_16 5'h10
// Address and commit bits ahead of the payload in a frame
`define ACMC_FRAME_OVERHEAD 5'h05

// Reference slew: codes moved per interval (2 mV per code)
`define ACMC_STEP_FAST 10'h064
`define ACMC_STEP_SLOW 10'h001
`define ACMC_STEP_INTERVAL_NS 30000
`define ACMC_CLOCK_PERIOD_NS 50

`endif

//--- src/acmc_pkg.sv
// Types shared by the scaling configuration and mode control block.
// Assumes acmc_consts.svh is on the include path.
`default_nettype none
`include "acmc_consts.svh"

package acmc_pkg;

	typedef enum logic [1:0] {
		ACMC_MODE_PMBUS,
		ACMC_MODE_SCALING,
		ACMC_MODE_BOOT
	} acmc_mode_t;

	typedef struct packed {
		logic scaling_mode_enable;
		logic startup_mode_request;
		logic double_commit_check;
		logic [1:0] payload_size;
		logic scaling_rate_bit;
	} acmc_cfg_t;

	typedef struct packed {
		logic write;
		logic read;
		logic restore;
		logic page;
		logic [7:0] code;
		logic [15:0] data;
	} acmc_cmd_t;

	typedef struct packed {
		logic valid;
		logic [4:0] count;
		logic [23:0] bits;
	} acmc_frame_t;

endpackage

`default_nettype wire

//--- src/acmc_link_sampler.sv
// Samples one scaling link on the controller clock and collects a frame.
// Assumes link pins are asynchronous; frame pin high marks a frame.
`default_nettype none
`include "acmc_consts.svh"

module acmc_link_sampler (
	input wire logic clock,
	input wire logic reset,
	input wire logic link_clock,
	input wire logic link_data,
	input wire logic link_frame,
	output acmc_pkg::acmc_frame_t frame
);

	logic [2:0] clock_sync;
	logic [1:0] data_sync;
	logic [2:0] frame_sync;
	logic [23:0] shift;
	logic [4:0] count;
	logic clock_rise;
	logic frame_rise;
	logic frame_fall;

	// Stage 0 feeds only stage 1; edges come from stages 1 and 2
	always_ff @(posedge clock) begin
		if (reset) begin
			clock_sync <= 3'h0;
			data_sync <= 2'h0;
			frame_sync <= 3'h0;
		end else begin
			clock_sync <= {clock_sync[1:0], link_clock};
			data_sync <= {data_sync[0], link_data};
			frame_sync <= {frame_sync[1:0], link_frame};
		end
	end

	assign clock_rise = clock_sync[1] & ~clock_sync[2];
	assign frame_rise = frame_sync[1] & ~frame_sync[2];
	assign frame_fall = ~frame_sync[1] & frame_sync[2];

	always_ff @(posedge clock) begin
		if (reset) begin
			shift <= 24'h000000;
			count <= 5'h00;
		end else if (frame_rise) begin
			shift <= 24'h000000;
			count <= 5'h00;
		end else if (frame_sync[1] && clock_rise) begin
			shift <= {shift[22:0], data_sync[1]};
			// Saturate so an overlong frame never wraps to a legal length
			if (count != 5'h1F) begin
				count <= count + 5'h01;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			frame <= '0;
		end else begin
			frame.valid <= frame_fall;
			frame.count <= count;
			frame.bits <= shift;
		end
	end

endmodule // acmc_link_sampler

`default_nettype wire

//--- src/acmc_top.sv
// Scaling link configuration, initial reference and mode control for two channels.
// Assumes a command decoder on the controller clock and two asynchronous scaling links.
//
// Function
// - Double-commit bit set: commit acts only after two identical commits; resets zero.
// - Two-bit payload code selects 8, 10, 12 or 16 bits; resets to 10.
// - Rate bit zero steps 200 mV per 30 us, one steps 2 mV.
// - At power cycle mode comes from stored enable and startup bits.
// - Without power cycle PMBus stays; scaling moves to boot on startup bit.
// - Startup bit cleared with enable set leaves boot mode for scaling mode.
// - Four-bit link device id, reset 5, matched only on link traffic.
// - Both channels in scaling mode: id write ignored, other fault, alert.
// - Only one channel in scaling mode: id writes accepted normally.
// - Writes to read-only upper bits are discarded; those bits stay fixed.
// - Power-up defaults load from saved user settings.
// - Each channel holds a 10-bit initial reference code, 2 mV steps.
// - Initial reference writable only in PMBus or boot mode, reloads too.
// - Blocked command write, not restore, sets other fault and alert.
// - Initial reference resets to 500; range runs 250 to 750.
// - Write outside limits rejected: summary bit, invalid-data bit, alert.
// - Boot mode ignores every command on the scaling link.
// - Soft-start follows rise-time ramp; afterwards the rate bit applies.
`default_nettype none
`include "acmc_consts.svh"

module acmc_top #(
	parameter int CHANNELS = 2
) (
	input wire logic clock,
	input wire logic reset,
	input wire acmc_pkg::acmc_cmd_t cmd,
	output logic [15:0] read_data,
	output logic read_valid,
	input wire logic [3:0] saved_device_id,
	input wire acmc_pkg::acmc_cfg_t [CHANNELS-1:0] saved_cfg,
	input wire logic [CHANNELS-1:0][9:0] saved_reference,
	input wire logic [CHANNELS-1:0][9:0] reference_upper_limit,
	input wire logic [CHANNELS-1:0][9:0] reference_lower_limit,
	input wire logic [CHANNELS-1:0] soft_start_busy,
	input wire logic [CHANNELS-1:0][9:0] soft_start_reference,
	input wire logic [CHANNELS-1:0] link_clock,
	input wire logic [CHANNELS-1:0] link_data,
	input wire logic [CHANNELS-1:0] link_frame,
	input wire logic status_clear,
	output acmc_pkg::acmc_mode_t [CHANNELS-1:0] mode,
	output logic [CHANNELS-1:0][9:0] reference_code,
	output logic status_other_fault,
	output logic status_invalid_data,
	output logic status_comm_summary,
	output logic alert
);

	localparam int STEP_CYCLES =
		(`ACMC_STEP_INTERVAL_NS + `ACMC_CLOCK_PERIOD_NS - 1) / `ACMC_CLOCK_PERIOD_NS;
	localparam logic [9:0] STEP_LAST = 10'(STEP_CYCLES - 1);

	function automatic logic [4:0] payload_width(input logic [1:0] size);
		unique case (size)
			`ACMC_PAYLOAD_8: payload_width = `ACMC_WIDTH_8;
			`ACMC_PAYLOAD_10: payload_width = `ACMC_WIDTH_10;
			`ACMC_PAYLOAD_12: payload_width = `ACMC_WIDTH_12;
			`ACMC_PAYLOAD_16: payload_width = `ACMC_WIDTH_16;
		endcase
	endfunction

	function automatic acmc_pkg::acmc_mode_t boot_mode(input acmc_pkg::acmc_cfg_t c);
		if (!c.scaling_mode_enable) begin
			boot_mode = acmc_pkg::ACMC_MODE_PMBUS;
		end else if (c.startup_mode_request) begin
			boot_mode = acmc_pkg::ACMC_MODE_BOOT;
		end else begin
			boot_mode = acmc_pkg::ACMC_MODE_SCALING;
		end
	endfunction

	function automatic logic in_limits(input logic [9:0] v, input logic [9:0] lo,
			input logic [9:0] hi);
		in_limits = (v >= lo) && (v <= hi);
	endfunction

	function automatic logic [9:0] clamp(input logic [9:0] v, input logic [9:0] lo,
			input logic [9:0] hi);
		clamp = (v > hi) ? hi : ((v < lo) ? lo : v);
	endfunction

	function automatic logic [9:0] step_toward(input logic [9:0] cur, input logic [9:0] tgt,
			input logic [9:0] step);
		if (tgt > cur) begin
			step_toward = (tgt - cur > step) ? cur + step : tgt;
		end else begin
			step_toward = (cur - tgt > step) ? cur - step : tgt;
		end
	endfunction

	logic boot_load;
	logic [3:0] link_device_id;
	acmc_pkg::acmc_cfg_t [CHANNELS-1:0] link_config;
	logic [CHANNELS-1:0][9:0] initial_reference_code;
	logic both_scaling;
	logic id_blocked;
	logic [CHANNELS-1:0] ref_blocked;
	logic [CHANNELS-1:0] ref_range_bad;
	logic other_set;
	logic invalid_set;
	logic write_id;
	logic write_cfg;
	logic write_ref;

	assign write_id = cmd.write && cmd.code == `ACMC_CODE_DEVICE_ID;
	assign write_cfg = cmd.write && cmd.code == `ACMC_CODE_LINK_CONFIG;
	assign write_ref = cmd.write && cmd.code == `ACMC_CODE_INIT_REF;

	always_comb begin
		both_scaling = 1'b1;
		for (int ch = 0; ch < CHANNELS; ch++) begin
			both_scaling &= (mode[ch] == acmc_pkg::ACMC_MODE_SCALING);
		end
	end

	assign id_blocked = write_id && both_scaling;

	// Power cycle: reset gives factory values, the cycle after release loads saved ones
	always_ff @(posedge clock) begin
		if (reset) begin
			boot_load <= 1'b1;
		end else begin
			boot_load <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			link_device_id <= `ACMC_RESET_DEVICE_ID;
		end else if (boot_load) begin
			link_device_id <= saved_device_id;
		end else if (write_id && !id_blocked) begin
			link_device_id <= cmd.data[3:0];
		end
	end

	genvar gc;
	generate
		for (gc = 0; gc < CHANNELS; gc++) begin : g_channel
			logic page_hit;
			acmc_pkg::acmc_frame_t frame;
			logic [4:0] width;
			logic [23:0] aligned;
			logic frame_ok;
			logic [3:0] frame_id;
			logic frame_commit;
			logic [9:0] frame_code;
			logic frame_taken;
			logic [9:0] pending_code;
			logic pending_valid;
			logic commit_apply;
			logic [9:0] link_target;
			logic link_seen;
			logic [9:0] target;
			logic [9:0] step_timer;
			logic [9:0] step_size;

			assign page_hit = cmd.page == 1'(gc);
			assign ref_blocked[gc] = write_ref && page_hit &&
				mode[gc] == acmc_pkg::ACMC_MODE_SCALING;
			assign ref_range_bad[gc] = write_ref && page_hit && !ref_blocked[gc] &&
				!in_limits(cmd.data[9:0], reference_lower_limit[gc],
				reference_upper_limit[gc]);

			always_ff @(posedge clock) begin
				if (reset) begin
					link_config[gc] <= {`ACMC_RESET_ENABLE, `ACMC_RESET_STARTUP,
						`ACMC_RESET_DOUBLE, `ACMC_RESET_PAYLOAD, `ACMC_RESET_SLEW};
				end else if (boot_load) begin
					link_config[gc] <= saved_cfg[gc];
				end else if (write_cfg && page_hit) begin
					link_config[gc] <= cmd.data[`ACMC_CFG_ENABLE:`ACMC_CFG_SLEW];
				end
			end

			always_ff @(posedge clock) begin
				if (reset) begin
					initial_reference_code[gc] <= `ACMC_RESET_INIT_REF;
				end else if (boot_load) begin
					initial_reference_code[gc] <= saved_reference[gc];
				end else if (write_ref && page_hit && !ref_blocked[gc] &&
						!ref_range_bad[gc]) begin
					initial_reference_code[gc] <= cmd.data[9:0];
				end
			end

			always_ff @(posedge clock) begin
				if (reset) begin
					mode[gc] <= acmc_pkg::ACMC_MODE_PMBUS;
				end else if (boot_load) begin
					mode[gc] <= boot_mode(saved_cfg[gc]);
				end else begin
					unique case (mode[gc])
						acmc_pkg::ACMC_MODE_PMBUS: begin
							mode[gc] <= acmc_pkg::ACMC_MODE_PMBUS;
						end
						acmc_pkg::ACMC_MODE_SCALING: begin
							if (link_config[gc].startup_mode_request) begin
								mode[gc] <= acmc_pkg::ACMC_MODE_BOOT;
							end
						end
						acmc_pkg::ACMC_MODE_BOOT: begin
							if (!link_config[gc].startup_mode_request &&
									link_config[gc].scaling_mode_enable) begin
								mode[gc] <= acmc_pkg::ACMC_MODE_SCALING;
							end
						end
					endcase
				end
			end

			acmc_link_sampler u_sampler (
				.clock(clock),
				.reset(reset),
				.link_clock(link_clock[gc]),
				.link_data(link_data[gc]),
				.link_frame(link_frame[gc]),
				.frame(frame)
			);

			// Frame: id, commit bit, then the payload, most significant bit first
			assign width = payload_width(link_config[gc].payload_size);
			assign aligned = frame.bits >> width;
			assign frame_ok = frame.valid && frame.count == width + `ACMC_FRAME_OVERHEAD;
			assign frame_id = aligned[4:1];
			assign frame_commit = aligned[0];
			assign frame_code = frame.bits[9:0];
			// Id matched on link traffic only; boot and PMBus modes drop frames
			assign frame_taken = frame_ok && frame_commit && frame_id == link_device_id &&
				mode[gc] == acmc_pkg::ACMC_MODE_SCALING;
			assign commit_apply = frame_taken && (!link_config[gc].double_commit_check ||
				(pending_valid && pending_code == frame_code));

			always_ff @(posedge clock) begin
				if (reset) begin
					pending_valid <= 1'b0;
					pending_code <= 10'h000;
				end else if (mode[gc] != acmc_pkg::ACMC_MODE_SCALING || commit_apply) begin
					pending_valid <= 1'b0;
				end else if (frame_taken) begin
					pending_valid <= 1'b1;
					pending_code <= frame_code;
				end
			end

			// Until the first applied command the initial code sets the target
			always_ff @(posedge clock) begin
				if (reset) begin
					link_seen <= 1'b0;
					link_target <= 10'h000;
				end else if (mode[gc] != acmc_pkg::ACMC_MODE_SCALING) begin
					link_seen <= 1'b0;
				end else if (commit_apply) begin
					link_seen <= 1'b1;
					link_target <= clamp(frame_code, reference_lower_limit[gc],
						reference_upper_limit[gc]);
				end
			end

			assign target = link_seen ? link_target : initial_reference_code[gc];
			assign step_size = link_config[gc].scaling_rate_bit ?
				`ACMC_STEP_SLOW : `ACMC_STEP_FAST;

			always_ff @(posedge clock) begin
				if (reset || soft_start_busy[gc] || step_timer == STEP_LAST) begin
					step_timer <= 10'h000;
				end else begin
					step_timer <= step_timer + 10'h001;
				end
			end

			always_ff @(posedge clock) begin
				if (reset) begin
					reference_code[gc] <= `ACMC_RESET_INIT_REF;
				end else if (soft_start_busy[gc]) begin
					reference_code[gc] <= soft_start_reference[gc];
				end else if (step_timer == STEP_LAST) begin
					reference_code[gc] <= step_toward(reference_code[gc], target,
						step_size);
				end
			end
		end
	endgenerate

	assign other_set = id_blocked || (!cmd.restore && |ref_blocked);
	assign invalid_set = |ref_range_bad;

	// A fault in the clearing cycle survives: set wins
	always_ff @(posedge clock) begin
		if (reset) begin
			status_other_fault <= 1'b0;
			status_invalid_data <= 1'b0;
			status_comm_summary <= 1'b0;
		end else begin
			status_other_fault <= other_set || (status_other_fault && !status_clear);
			status_invalid_data <= invalid_set || (status_invalid_data && !status_clear);
			status_comm_summary <= other_set || invalid_set ||
				(status_comm_summary && !status_clear);
		end
	end

	assign alert = status_other_fault || status_invalid_data || status_comm_summary;

	// Upper bits read as zero; unmapped codes read as zero
	always_ff @(posedge clock) begin
		if (reset) begin
			read_data <= 16'h0000;
			read_valid <= 1'b0;
		end else begin
			read_valid <= cmd.read;
			if (cmd.read) begin
				unique case (cmd.code)
					`ACMC_CODE_DEVICE_ID: read_data <= {12'h000, link_device_id};
					`ACMC_CODE_INIT_REF: read_data <= {6'h00,
						initial_reference_code[cmd.page]};
					`ACMC_CODE_LINK_CONFIG: read_data <= {10'h000, link_config[cmd.page]};
					default: read_data <= 16'h0000;
				endcase
			end
		end
	end

endmodule // acmc_top

`default_nettype wire

//--- verif/acmc_top_chk.sv
// Checker on the ports of the scaling config and mode control block.
// Assumes one controller clock domain and synchronous active-high reset.
`default_nettype none
`include "acmc_consts.svh"

module acmc_top_chk #(
	parameter int CHANNELS = 2
) (
	input wire logic clock,
	input wire logic reset,
	input wire acmc_pkg::acmc_cmd_t cmd,
	input wire logic [15:0] read_data,
	input wire logic read_valid,
	input wire logic [CHANNELS-1:0][9:0] reference_upper_limit,
	input wire logic [CHANNELS-1:0][9:0] reference_lower_limit,
	input wire logic status_clear,
	input wire acmc_pkg::acmc_mode_t [CHANNELS-1:0] mode,
	input wire logic status_other_fault,
	input wire logic status_invalid_data,
	input wire logic status_comm_summary,
	input wire logic alert
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	sequence s_ref_write;
		cmd.write && cmd.code == `ACMC_CODE_INIT_REF;
	endsequence
	sequence s_id_write;
		cmd.write && cmd.code == `ACMC_CODE_DEVICE_ID;
	endsequence
	sequence s_cfg_write(pg);
		cmd.write && cmd.code == `ACMC_CODE_LINK_CONFIG && cmd.page == pg;
	endsequence

	chk_read_pulse: assert property (cmd.read |=> read_valid)
		else $error("read not answered next cycle");
	chk_read_quiet: assert property (!cmd.read |=> !read_valid && $stable(read_data))
		else $error("read data moved without a read");
	chk_alert_or: assert property (
		alert == (status_other_fault || status_invalid_data || status_comm_summary))
		else $error("alert not the OR of status bits");
	chk_range_refused: assert property (
		s_ref_write ##0 (mode[cmd.page] != acmc_pkg::ACMC_MODE_SCALING
		&& (cmd.data[9:0] > reference_upper_limit[cmd.page]
		|| cmd.data[9:0] < reference_lower_limit[cmd.page]))
		|=> status_invalid_data && status_comm_summary)
		else $error("out of range reference not flagged");
	chk_ref_blocked: assert property (
		s_ref_write ##0 (!cmd.restore && mode[cmd.page] == acmc_pkg::ACMC_MODE_SCALING)
		|=> status_other_fault && status_comm_summary)
		else $error("blocked reference write not flagged");
	chk_restore_quiet: assert property (
		s_ref_write ##0 (cmd.restore && !status_clear
		&& mode[cmd.page] == acmc_pkg::ACMC_MODE_SCALING)
		|=> $stable(status_other_fault))
		else $error("blocked restore raised a fault");
	chk_id_locked: assert property (
		s_id_write ##0 (mode[0] == acmc_pkg::ACMC_MODE_SCALING
		&& mode[1] == acmc_pkg::ACMC_MODE_SCALING) |=> status_other_fault)
		else $error("locked id write not flagged");
	chk_id_open: assert property (
		s_id_write ##0 (!status_other_fault && !status_clear
		&& !(mode[0] == acmc_pkg::ACMC_MODE_SCALING
		&& mode[1] == acmc_pkg::ACMC_MODE_SCALING))
		|=> !status_other_fault)
		else $error("open id write flagged");
	chk_pmbus_kept: assert property (
		!$past(reset) && mode[0] == acmc_pkg::ACMC_MODE_PMBUS
		|=> mode[0] == acmc_pkg::ACMC_MODE_PMBUS)
		else $error("left PMBus mode without power cycle");
	chk_boot_entry: assert property (
		s_cfg_write(1'b0) ##0 (cmd.data[`ACMC_CFG_STARTUP]
		&& mode[0] == acmc_pkg::ACMC_MODE_SCALING)
		|-> ##[1:3] mode[0] == acmc_pkg::ACMC_MODE_BOOT)
		else $error("startup request did not enter boot mode");
	chk_boot_exit: assert property (
		s_cfg_write(1'b1) ##0 (cmd.data[`ACMC_CFG_ENABLE] && !cmd.data[`ACMC_CFG_STARTUP]
		&& mode[1] == acmc_pkg::ACMC_MODE_BOOT)
		|-> ##[1:3] mode[1] == acmc_pkg::ACMC_MODE_SCALING)
		else $error("boot mode not left on cleared request");
endmodule // acmc_top_chk

bind acmc_top acmc_top_chk #(.CHANNELS(CHANNELS)) acmc_top_chk_i (.clock(clock), .reset(reset),
	.cmd(cmd), .read_data(read_data), .read_valid(read_valid),
	.reference_upper_limit(reference_upper_limit), .reference_lower_limit(reference_lower_limit),
	.status_clear(status_clear), .mode(mode), .status_other_fault(status_other_fault),
	.status_invalid_data(status_invalid_data), .status_comm_summary(status_comm_summary),
	.alert(alert));

`default_nettype wire

//--- verif/acmc_link_master.sv
// Model of the scaling link master driving one channel's link pins.
// Assumes the bench calls send_frame; link clock period 400 ns.
`default_nettype none

module acmc_link_master (
	output logic link_clock,
	output logic link_data,
	output logic link_frame
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		link_clock = 1'b0;
		link_data = 1'b1;
		link_frame = 1'b0;
	end

	// Commit bit always set; clock stands still between frames
	task automatic send_frame(input logic [3:0] id, input logic [15:0] payload, input int nbits);
		logic [20:0] word;
		word = (21'({id, 1'b1}) << nbits) | 21'(payload);
		link_frame = 1'b1;
		for (int i = nbits + 4; i >= 0; i--) begin
			link_data = word[i];
			#200 link_clock = 1'b1;
			#200 link_clock = 1'b0;
		end
		#200 link_frame = 1'b0;
		// Released data must not look like a held bit
		link_data = ~link_data;
		// Idle gap so a following frame shows a clean fall first
		#400;
	endtask
endmodule // acmc_link_master

`default_nettype wire

//--- verif/acmc_top_tb.sv
// Self-checking bench for the scaling config and mode control block.
// Assumes the link master model and the bound checker are compiled first.
`default_nettype none

module acmc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic reset = 1'b1;
	acmc_pkg::acmc_cmd_t cmd = '0;
	logic [15:0] read_data;
	logic read_valid;
	logic [3:0] saved_device_id = 4'h9;
	acmc_pkg::acmc_cfg_t [1:0] saved_cfg = {6'h02, 6'h02};
	logic [1:0][9:0] saved_reference = {10'h12C, 10'h12C};
	logic [1:0][9:0] reference_upper_limit = {10'h2EE, 10'h2EE};
	logic [1:0][9:0] reference_lower_limit = {10'h0FA, 10'h0FA};
	logic [1:0] soft_start_busy = 2'h0;
	logic [1:0][9:0] soft_start_reference = {10'h000, 10'h000};
	wire logic [1:0] link_clock;
	wire logic [1:0] link_data;
	wire logic [1:0] link_frame;
	logic status_clear = 1'b0;
	acmc_pkg::acmc_mode_t [1:0] mode;
	logic [1:0][9:0] reference_code;
	logic status_other_fault;
	logic status_invalid_data;
	logic status_comm_summary;
	logic alert;
	logic [15:0] lv[4] = '{16'h02EF, 16'h00F9, 16'h02EE, 16'h00FA};
	logic [15:0] re[4] = '{16'h012C, 16'h012C, 16'h02EE, 16'h00FA};
	logic [3:0] se[4] = '{4'hB, 4'hB, 4'h0, 4'h0};
	int mismatches = 0;
	int compares = 0;

	always #25 clock = ~clock;

	acmc_top acmc_top_i (.clock(clock), .reset(reset), .cmd(cmd), .read_data(read_data),
		.read_valid(read_valid), .saved_device_id(saved_device_id), .saved_cfg(saved_cfg),
		.saved_reference(saved_reference), .reference_upper_limit(reference_upper_limit),
		.reference_lower_limit(reference_lower_limit), .soft_start_busy(soft_start_busy),
		.soft_start_reference(soft_start_reference), .link_clock(link_clock),
		.link_data(link_data), .link_frame(link_frame), .status_clear(status_clear), .mode(mode),
		.reference_code(reference_code), .status_other_fault(status_other_fault),
		.status_invalid_data(status_invalid_data), .status_comm_summary(status_comm_summary),
		.alert(alert));
	acmc_link_master link0_i (.link_clock(link_clock[0]), .link_data(link_data[0]),
		.link_frame(link_frame[0]));
	acmc_link_master link1_i (.link_clock(link_clock[1]), .link_data(link_data[1]),
		.link_frame(link_frame[1]));

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic pg, input logic [7:0] code, input logic [15:0] d, input logic rs);
		@(negedge clock);
		cmd = '{1'b1, 1'b0, rs, pg, code, d};
		@(negedge clock);
		cmd = '0;
	endtask

	task automatic rd(input logic pg, input logic [7:0] code, input logic [15:0] exp);
		@(negedge clock);
		cmd = '{1'b0, 1'b1, 1'b0, pg, code, 16'h0000};
		@(negedge clock);
		cmd = '0;
		check({15'h0000, read_valid}, 16'h0001, "read pulse");
		check(read_data, exp, "read data");
	endtask

	task automatic st(input logic [3:0] e);
		check({12'h000, alert, status_other_fault, status_invalid_data, status_comm_summary},
			{12'h000, e}, "status");
	endtask

	task automatic clr;
		@(negedge clock);
		status_clear = 1'b1;
		@(negedge clock);
		status_clear = 1'b0;
	endtask

	task automatic md(input logic ch, input acmc_pkg::acmc_mode_t e);
		repeat (3) @(negedge clock);
		check({14'h0000, mode[ch]}, {14'h0000, e}, "mode");
	endtask

	task automatic pc;
		@(negedge clock);
		reset = 1'b1;
		repeat (16) @(negedge clock);
		reset = 1'b0;
		repeat (2) @(negedge clock);
	endtask

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		pc();
		rd(1'b0, 8'hEA, 16'h0009);
		rd(1'b0, 8'hEB, 16'h012C);
		rd(1'b1, 8'hE9, 16'h0002);
		wr(1'b0, 8'hEA, 16'hFFF3, 1'b0);
		rd(1'b0, 8'hEA, 16'h0003);
		wr(1'b0, 8'hEB, 16'hFE58, 1'b0);
		rd(1'b0, 8'hEB, 16'h0258);
		for (int i = 0; i < 4; i++) begin
			wr(1'b1, 8'hEB, lv[i], 1'b0);
			st(se[i]);
			rd(1'b1, 8'hEB, re[i]);
			clr();
		end
		// The 8-bit payload code 0 is never chosen
		for (int p = 3; p > 0; p--) begin
			wr(1'b1, 8'hE9, 16'(p << 1), 1'b0);
			rd(1'b1, 8'hE9, 16'(p << 1));
		end
		wr(1'b0, 8'hE9, 16'h0032, 1'b0);
		md(1'b0, acmc_pkg::ACMC_MODE_PMBUS);
		saved_cfg = {6'h32, 6'h2A};
		pc();
		md(1'b0, acmc_pkg::ACMC_MODE_SCALING);
		md(1'b1, acmc_pkg::ACMC_MODE_BOOT);
		wr(1'b0, 8'hEA, 16'h0006, 1'b0);
		rd(1'b0, 8'hEA, 16'h0006);
		wr(1'b1, 8'hEB, 16'h0190, 1'b0);
		rd(1'b1, 8'hEB, 16'h0190);
		st(4'h0);
		wr(1'b0, 8'hEB, 16'h0190, 1'b0);
		st(4'hD);
		clr();
		wr(1'b0, 8'hEB, 16'h0190, 1'b1);
		st(4'h0);
		rd(1'b0, 8'hEB, 16'h012C);
		// Let both references settle on their initial codes first
		repeat (1500) @(negedge clock);
		link1_i.send_frame(4'h6, 16'h0258, 10);
		link0_i.send_frame(4'h6, 16'h0258, 10);
		repeat (700) @(negedge clock);
		check({6'h00, reference_code[1]}, 16'h0190, "boot link");
		check({6'h00, reference_code[0]}, 16'h012C, "single commit");
		link0_i.send_frame(4'h6, 16'h0258, 10);
		repeat (2100) @(negedge clock);
		check({6'h00, reference_code[0]}, 16'h0258, "double commit");
		// Double check and payload stay as stored while enabled
		wr(1'b1, 8'hE9, 16'h0022, 1'b0);
		md(1'b1, acmc_pkg::ACMC_MODE_SCALING);
		wr(1'b0, 8'hEA, 16'h0007, 1'b0);
		st(4'hD);
		rd(1'b0, 8'hEA, 16'h0006);
		clr();
		wr(1'b0, 8'hE9, 16'h003A, 1'b0);
		md(1'b0, acmc_pkg::ACMC_MODE_BOOT);
		// Wrong id and wrong length must be dropped; a taken code would pull 400 down to 300
		link1_i.send_frame(4'h7, 16'h012C, 10);
		link1_i.send_frame(4'h6, 16'h012C, 12);
		repeat (650) @(negedge clock);
		check({6'h00, reference_code[1]}, 16'h0190, "dropped frames");
		// Slow rate: one or two codes in about one interval, fast would reach 500
		wr(1'b1, 8'hE9, 16'h0023, 1'b0);
		link1_i.send_frame(4'h6, 16'h01F4, 10);
		repeat (650) @(negedge clock);
		check({15'h0000, reference_code[1] inside {10'h191, 10'h192}}, 16'h0001,
			"slow rate");
		soft_start_reference[0] = 10'h0C8;
		soft_start_busy[0] = 1'b1;
		repeat (2) @(negedge clock);
		check({6'h00, reference_code[0]}, 16'h00C8, "soft start");
		soft_start_busy[0] = 1'b0;
		tally_and_finish();
	end

	initial begin
		#3000000;
		mismatches++;
		$display("BAD %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule // acmc_top_tb

`default_nettype wire
